// ---- rtl/wsc_pkg.sv ----
// Purpose: Shared constants, types and helpers of the weight setpoint comparator
// Assumes: 100 MHz system clock, 24-bit unsigned weights
// Notes: Register offsets are byte addresses on the plain register port
package wsc_pkg;
    localparam int VW = 24;
    localparam logic [23:0] VAL_MAX = 24'h98_967F;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam int FRAC = 16;
    // Register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TARGET = 8'h04;
    localparam logic [7:0] A_HALF = 8'h08;
    localparam logic [7:0] A_REARM = 8'h0C;
    localparam logic [7:0] A_OFFSET = 8'h10;
    localparam logic [7:0] A_FACTOR = 8'h14;
    localparam logic [7:0] A_SETTLE = 8'h18;
    localparam logic [7:0] A_RELEARN = 8'h1C;
    localparam logic [7:0] A_STATUS = 8'h20;
    localparam logic [7:0] A_CMD = 8'h24;
    // Control and command fields
    localparam int CTRL_W = 11;
    localparam int CTL_KIND = 0;
    localparam int CTL_TRIP = 2;
    localparam int CTL_CUT = 4;
    localparam int CTL_BATCH = 6;
    localparam int CTL_SRC = 8;
    localparam int SRC_W = 3;
    localparam int CMD_START = 0;
    localparam int CMD_CLRCNT = 1;
    // Status fields
    localparam int STS_SAT = 0;
    localparam int STS_OUT = 1;
    localparam int STS_ARMED = 2;
    localparam int STS_STATE = 3;
    localparam int STS_CNT = 16;
    // Reset values
    localparam logic [10:0] CTRL_RST = 11'h000;
    localparam logic [23:0] VAL_RST = 24'h00_0000;
    localparam logic [16:0] FACTOR_RST = 17'h0_8000;
    localparam logic [15:0] SETTLE_RST = 16'h0000;
    localparam logic [15:0] RELEARN_RST = 16'h0001;
    // Timing
    localparam int CLK_NS = 10;
    localparam int TENTH_NS = 100_000_000;
    localparam int TENTH_CYC = (TENTH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        KIND_WEIGHT = 2'b00,
        KIND_TIME = 2'b01,
        KIND_COUNT = 2'b10
    } wsc_kind_t;

    typedef enum logic [1:0] {
        TRIP_ABOVE = 2'b00,
        TRIP_BELOW = 2'b01,
        TRIP_WITHIN_WINDOW = 2'b10,
        TRIP_OUTSIDE_WINDOW = 2'b11
    } wsc_trip_t;

    typedef enum logic [1:0] {
        CUT_NONE = 2'b00,
        CUT_FIXED = 2'b01,
        CUT_ADAPT = 2'b10,
        CUT_FLOW = 2'b11
    } wsc_cut_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_SETTLE = 2'b10
    } wsc_state_t;

    function automatic logic [23:0] wsc_sub(input logic [23:0] a, input logic [23:0] b);
        return (a > b) ? a - b : VAL_RST;
    endfunction

    function automatic logic [23:0] wsc_add(input logic [23:0] a, input logic [23:0] b);
        logic [24:0] s;
        s = {1'b0, a} + {1'b0, b};
        return (s > {1'b0, VAL_MAX}) ? VAL_MAX : s[23:0];
    endfunction

    function automatic logic [23:0] wsc_clamp(input logic [31:0] v);
        return (v > {8'h00, VAL_MAX}) ? VAL_MAX : v[23:0];
    endfunction

    function automatic logic wsc_hit(input logic [23:0] cv, input logic [23:0] t,
                                     input logic [23:0] h, input wsc_trip_t trip);
        logic [23:0] lo;
        logic [23:0] hi;
        lo = wsc_sub(t, h);
        hi = wsc_add(t, h);
        unique case (trip)
            TRIP_ABOVE: return cv >= t;
            TRIP_BELOW: return cv < t;
            TRIP_WITHIN_WINDOW: return (cv >= lo) && (cv <= hi);
            TRIP_OUTSIDE_WINDOW: return (cv < lo) || (cv > hi);
        endcase
    endfunction
endpackage

// ---- rtl/wsc_tenth_timer.sv ----
// Purpose: Tenth-of-a-second tick and saturating tenths counter
// Assumes: Tick period given in system clock cycles
// Notes: Clear restarts both the divider and the count
`timescale 1ns/1ps
module wsc_tenth_timer import wsc_pkg::*; #(
    parameter int TICK_CYC = TENTH_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control
    input wire logic clr,
    input wire logic run,
    // Count
    output logic [15:0] tenths_q,
    output logic tick_q
);
    logic [31:0] div_q;
    logic wrap;

    assign wrap = (div_q == 32'(TICK_CYC - 1));

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            div_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end
        else if (clr || !run)
        begin
            div_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end
        else
        begin
            div_q <= wrap ? 32'h0000_0000 : div_q + 32'h0000_0001;
            tick_q <= wrap;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            tenths_q <= 16'h0000;
        else if (clr)
            tenths_q <= 16'h0000;
        else if (tick_q && tenths_q != CNT_MAX)
            tenths_q <= tenths_q + 16'h0001;
    end
endmodule

// ---- rtl/wsc_setpoint.sv ----
// Purpose: One setpoint: target compare, hysteresis, batch output, early cutoff
// Assumes: Weight samples arrive as one-cycle strobes tagged with a scale number
// Notes: Registers sit on a plain port, read data valid one cycle after the strobe
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Function
// [RULE_01] Weight targets span zero to 9999999 and compare against the selected weight.
// [RULE_02] Time targets count tenths of a second, zero to 65535.
// [RULE_03] Count targets give the number of batches to run, zero to 65535.
// [RULE_04] Compared weight comes from the scale chosen by the source field.
// [RULE_05] Satisfied when above, below, inside or outside the target window.
// [RULE_06] Batch step above target holds output on until weight reaches target.
// [RULE_07] Batch step below target holds output on until weight drops below.
// [RULE_08] Window is target minus to plus half-width, half-width up to 9999999.
// [RULE_09] After turning off, no new trip until weight passes the rearm margin.
// [RULE_10] Early cutoff turns the output off before satisfaction for material in flight.
// [RULE_11] Fixed cutoff shifts the trip value by the offset, direction per condition.
// [RULE_12] Cutoff offset spans zero to 9999999, used by fixed, adaptive and flow modes.
// [RULE_13] Adaptive mode corrects the offset by factor times settled weight error.
// [RULE_14] Correction factor is fractional, resets to one half, one means full.
// [RULE_15] Wait for standstill up to a nonzero timeout, else skip adaptation.
// [RULE_16] Adapt only once per relearn interval batches, default every batch.
// [RULE_17] Flow mode predicts weight from its rate and cuts off ahead of trip.
// [RULE_18] A batch selection makes the setpoint a batch step or continuous.
// [RULE_19] Evaluate per weight update strobe, registering flags on the clock edge; time and count kinds evaluate every cycle.
// [RULE_20] Factor is Q1.16 and the adjusted offset saturates to its range.
module wsc_setpoint import wsc_pkg::*; #(
    parameter int TICK_CYC = TENTH_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q,
    // Weight source
    input wire logic wt_valid,
    input wire logic [2:0] wt_scale,
    input wire logic [23:0] wt_value,
    input wire logic standstill,
    // Feeder and status
    output logic feeder_out_q,
    output logic satisfied_q,
    output logic batch_done_q
);
    logic [10:0] ctrl_q;
    logic [23:0] target_q;
    logic [23:0] half_q;
    logic [23:0] rearm_q;
    logic [23:0] offset_q;
    logic [16:0] factor_q;
    logic [15:0] settle_q;
    logic [15:0] relearn_q;
    logic [23:0] wt_q;
    logic [23:0] prev_q;
    logic upd_q;
    logic armed_q;
    logic [15:0] batch_cnt_q;
    logic [15:0] lrn_q;
    wsc_state_t state_q;

    wsc_kind_t kind;
    wsc_trip_t trip;
    wsc_cut_t cut;
    logic batch;
    logic [2:0] src;
    logic [15:0] tenths;
    logic tmr_clr;
    logic start;
    logic clrcnt;
    logic ev;
    logic hit;
    logic beyond;
    logic reached;
    logic learn_due;
    logic timeout;
    logic over;
    logic [23:0] cv;
    logic [23:0] tgt;
    logic [23:0] pred;
    logic [23:0] cut_cv;
    logic [23:0] trip_eff;
    logic [23:0] mag;
    logic [40:0] prod;
    logic [23:0] corr;
    logic [23:0] learn_ofs;
    logic [31:0] sts;

    assign kind = wsc_kind_t'(ctrl_q[CTL_KIND +: 2]);
    assign trip = wsc_trip_t'(ctrl_q[CTL_TRIP +: 2]);
    assign cut = wsc_cut_t'(ctrl_q[CTL_CUT +: 2]);
    assign batch = ctrl_q[CTL_BATCH]; // [RULE_18]
    assign src = ctrl_q[CTL_SRC +: SRC_W];
    assign start = reg_wr && (reg_addr == A_CMD) && reg_wdata[CMD_START];
    assign clrcnt = reg_wr && (reg_addr == A_CMD) && reg_wdata[CMD_CLRCNT];

    // Configuration registers
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= CTRL_RST;
            target_q <= VAL_RST;
            half_q <= VAL_RST;
            rearm_q <= VAL_RST;
            factor_q <= FACTOR_RST; // [RULE_14]
            settle_q <= SETTLE_RST;
            relearn_q <= RELEARN_RST; // [RULE_16]
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                A_CTRL: ctrl_q <= reg_wdata[CTRL_W-1:0];
                A_TARGET: target_q <= wsc_clamp(reg_wdata); // [RULE_01]
                A_HALF: half_q <= wsc_clamp(reg_wdata); // [RULE_08]
                A_REARM: rearm_q <= wsc_clamp(reg_wdata); // [RULE_09]
                A_FACTOR: factor_q <= reg_wdata[16:0]; // [RULE_20]
                A_SETTLE: settle_q <= reg_wdata[15:0]; // [RULE_15]
                A_RELEARN: relearn_q <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Tenths timer shared by batch duration and settle wait
    assign tmr_clr = ((state_q == ST_IDLE) && batch && start) ||
                     ((state_q == ST_RUN) && ev && reached);

    wsc_tenth_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clr(tmr_clr),
        .run(state_q != ST_IDLE),
        .tenths_q(tenths),
        .tick_q()
    );

    // Latch samples of the selected scale only
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wt_q <= VAL_RST;
            prev_q <= VAL_RST;
            upd_q <= 1'b0;
        end
        else if (wt_valid && (wt_scale == src)) // [RULE_04]
        begin
            prev_q <= wt_q;
            wt_q <= wsc_clamp({8'h00, wt_value});
            upd_q <= 1'b1; // [RULE_19]
        end
        else
            upd_q <= 1'b0;
    end

    // Compared value and target per kind
    always_comb
    begin
        cv = wt_q;
        tgt = target_q;
        case (kind)
            KIND_TIME:
            begin
                cv = {8'h00, tenths}; // [RULE_02]
                tgt = {8'h00, target_q[15:0]};
            end
            KIND_COUNT:
            begin
                cv = {8'h00, batch_cnt_q}; // [RULE_03]
                tgt = {8'h00, target_q[15:0]};
            end
            default: ;
        endcase
    end

    // Weight kind evaluates per sample, counters every cycle
    assign ev = (kind != KIND_WEIGHT) || upd_q; // [RULE_19]
    assign hit = wsc_hit(cv, tgt, half_q, trip); // [RULE_05]

    always_comb
    begin
        unique case (trip)
            TRIP_ABOVE: beyond = cv < wsc_sub(tgt, rearm_q); // [RULE_09]
            TRIP_BELOW: beyond = cv > wsc_add(tgt, rearm_q);
            TRIP_WITHIN_WINDOW,
            TRIP_OUTSIDE_WINDOW: beyond = (cv < wsc_sub(tgt, rearm_q)) ||
                                          (cv > wsc_add(tgt, rearm_q));
        endcase
    end

    // One-sample-ahead extrapolation of the weight
    assign pred = (trip == TRIP_BELOW) ? wsc_sub(wt_q, wsc_sub(prev_q, wt_q)) :
                  wsc_add(wt_q, wsc_sub(wt_q, prev_q)); // [RULE_17]
    assign cut_cv = ((cut == CUT_FLOW) && (kind == KIND_WEIGHT)) ? pred : cv; // [RULE_17]

    always_comb
    begin
        if (cut == CUT_NONE)
            trip_eff = tgt;
        else if (trip == TRIP_BELOW)
            trip_eff = wsc_add(tgt, offset_q); // [RULE_11]
        else
            trip_eff = wsc_sub(tgt, offset_q); // [RULE_11]
        unique case (trip)
            TRIP_ABOVE: reached = cut_cv >= trip_eff; // [RULE_06]
            TRIP_BELOW: reached = cut_cv < trip_eff; // [RULE_07]
            TRIP_WITHIN_WINDOW,
            TRIP_OUTSIDE_WINDOW: reached = hit;
        endcase
    end

    // Satisfied flag with rearm hysteresis
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            satisfied_q <= 1'b0;
            armed_q <= 1'b1;
        end
        else if (ev)
        begin
            if (satisfied_q && !hit)
            begin
                satisfied_q <= 1'b0;
                armed_q <= 1'b0; // [RULE_09]
            end
            else if (!satisfied_q && hit && armed_q)
                satisfied_q <= 1'b1; // [RULE_05]
            else if (!armed_q && beyond)
                armed_q <= 1'b1; // [RULE_09]
        end
    end

    assign learn_due = (relearn_q != 16'h0000) && ((lrn_q + 16'h0001) >= relearn_q); // [RULE_16]
    assign timeout = (settle_q != 16'h0000) && (tenths >= settle_q); // [RULE_15]

    // Batch sequencing and feeder output
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            feeder_out_q <= 1'b0;
            batch_done_q <= 1'b0;
            batch_cnt_q <= 16'h0000;
            lrn_q <= 16'h0000;
        end
        else
        begin
            batch_done_q <= 1'b0;
            if (clrcnt)
                batch_cnt_q <= 16'h0000;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (batch && start)
                    begin
                        state_q <= ST_RUN;
                        feeder_out_q <= 1'b1; // [RULE_06]
                    end
                    else
                        feeder_out_q <= !batch && satisfied_q; // [RULE_18]
                end
                ST_RUN:
                begin
                    if (!batch)
                    begin
                        state_q <= ST_IDLE;
                        feeder_out_q <= 1'b0;
                    end
                    else if (ev && reached)
                    begin
                        feeder_out_q <= 1'b0; // [RULE_10]
                        batch_done_q <= 1'b1;
                        if (batch_cnt_q != CNT_MAX)
                            batch_cnt_q <= batch_cnt_q + 16'h0001;
                        if (cut == CUT_ADAPT && kind == KIND_WEIGHT)
                            lrn_q <= learn_due ? 16'h0000 : lrn_q + 16'h0001;
                        if (cut == CUT_ADAPT && kind == KIND_WEIGHT && learn_due)
                            state_q <= ST_SETTLE; // [RULE_16]
                        else
                            state_q <= ST_IDLE;
                    end
                end
                ST_SETTLE:
                begin
                    feeder_out_q <= 1'b0;
                    if (!batch || standstill || timeout)
                        state_q <= ST_IDLE; // [RULE_15]
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    feeder_out_q <= 1'b0;
                end
            endcase
        end
    end

    // Learned offset from settled error
    assign over = (trip == TRIP_BELOW) ? (wt_q < target_q) : (wt_q > target_q);
    assign mag = (wt_q > target_q) ? wt_q - target_q : target_q - wt_q;
    assign prod = 41'(factor_q) * 41'(mag); // [RULE_13]
    assign corr = (prod[40:FRAC] > {1'b0, VAL_MAX}) ? VAL_MAX : prod[39:FRAC]; // [RULE_20]
    assign learn_ofs = over ? wsc_add(offset_q, corr) : wsc_sub(offset_q, corr); // [RULE_20]

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            offset_q <= VAL_RST;
        else if (reg_wr && reg_addr == A_OFFSET)
            offset_q <= wsc_clamp(reg_wdata); // [RULE_12]
        else if (state_q == ST_SETTLE && batch && standstill)
            offset_q <= learn_ofs; // [RULE_13]
    end

    // Read path
    always_comb
    begin
        sts = 32'h0000_0000;
        sts[STS_SAT] = satisfied_q;
        sts[STS_OUT] = feeder_out_q;
        sts[STS_ARMED] = armed_q;
        sts[STS_STATE +: 2] = state_q;
        sts[STS_CNT +: 16] = batch_cnt_q;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            reg_rdata_q <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                A_CTRL: reg_rdata_q <= 32'(ctrl_q);
                A_TARGET: reg_rdata_q <= {8'h00, target_q};
                A_HALF: reg_rdata_q <= {8'h00, half_q};
                A_REARM: reg_rdata_q <= {8'h00, rearm_q};
                A_OFFSET: reg_rdata_q <= {8'h00, offset_q};
                A_FACTOR: reg_rdata_q <= 32'(factor_q);
                A_SETTLE: reg_rdata_q <= {16'h0000, settle_q};
                A_RELEARN: reg_rdata_q <= {16'h0000, relearn_q};
                A_STATUS: reg_rdata_q <= sts;
                default: reg_rdata_q <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata_q <= 32'h0000_0000;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    cont_follow_a: // [RULE_18]
    assert property ((state_q == ST_IDLE) && !batch && !start |=>
                     feeder_out_q == $past(satisfied_q))
    else $error("continuous output does not follow satisfied flag");
    start_run_a: // [RULE_06]
    assert property ((state_q == ST_IDLE) && batch && start |=>
                     (state_q == ST_RUN) && feeder_out_q)
    else $error("batch start did not turn feeder on");
    run_out_a: // [RULE_07]
    assert property ((state_q == ST_RUN) |-> feeder_out_q)
    else $error("feeder off while batch step running");
    cut_stop_a: // [RULE_10]
    assert property ((state_q == ST_RUN) && batch && ev && reached |=>
                     !feeder_out_q && batch_done_q)
    else $error("feeder not cut at trip");
    fall_disarm_a: // [RULE_09]
    assert property ($fell(satisfied_q) |-> !armed_q)
    else $error("setpoint turned off without disarming");
    no_retrip_a: // [RULE_09]
    assert property (!armed_q |=> !$rose(satisfied_q))
    else $error("setpoint tripped while disarmed");
    offset_range_a: // [RULE_20]
    assert property (offset_q <= VAL_MAX)
    else $error("cutoff offset out of range");
    settle_skip_a: // [RULE_15]
    assert property ((state_q == ST_SETTLE) && !standstill && timeout |=>
                     (state_q == ST_IDLE) && $stable(offset_q))
    else $error("settle timeout did not skip adaptation");
    learn_gate_a: // [RULE_16]
    assert property ((state_q == ST_RUN) && ev && reached && !learn_due |=> state_q != ST_SETTLE)
    else $error("adaptation entered before relearn interval");
    rd_once_a: // [RULE_19]
    assert property (!reg_rd |=> reg_rdata_q == 32'h0000_0000)
    else $error("read data outside read cycle");

    batch_done_c: cover property ((state_q == ST_RUN) ##[1:1000] batch_done_q);
    learn_c: cover property ((state_q == ST_SETTLE) && standstill && batch);
    timeout_c: cover property ((state_q == ST_SETTLE) && timeout && !standstill);
    cont_trip_c: cover property (!batch ##1 $rose(satisfied_q));
endmodule

// ---- bench/wsc_scale_model.sv ----
// Purpose: Scale weight source whose weight moves while the feeder runs
// Assumes: One sample strobe every four clocks
// Notes: Sample lines carry inverted data between strobes
`timescale 1ns/1ps
module wsc_scale_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Test control
    input wire logic set_en,
    input wire logic [23:0] set_val,
    input wire logic [23:0] flow,
    input wire logic [2:0] scale,
    input wire logic motion,
    // Device side
    input wire logic feeder_out_q,
    output logic wt_valid,
    output logic [2:0] wt_scale,
    output logic [23:0] wt_value,
    output logic standstill
);
    logic [1:0] div_q;
    logic v_q;
    logic [23:0] w_q;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            div_q <= 2'h0;
            v_q <= 1'b0;
            w_q <= 24'h00_0000;
        end
        else
        begin
            div_q <= div_q + 2'h1;
            v_q <= (div_q == 2'h3);
            if (set_en)
                w_q <= set_val;
            else if (div_q == 2'h3 && feeder_out_q)
                w_q <= w_q + flow;
        end
    end

    assign wt_valid = v_q;
    assign wt_scale = v_q ? scale : ~scale;
    assign wt_value = v_q ? w_q : ~w_q;
    assign standstill = !feeder_out_q && !motion;
endmodule

// ---- bench/testbench.sv ----
// Purpose: Register, continuous and batch checks of one setpoint
// Assumes: Scale model samples every four clocks, short tenth tick
// Notes: Waits of ten clocks cover one sample plus evaluation
`timescale 1ns/1ps
module testbench import wsc_pkg::*; ();
    logic clk_sys = 0;
    logic nrst = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [31:0] reg_rdata_q;
    logic wt_valid, standstill, feeder_out_q, satisfied_q, batch_done_q;
    logic [2:0] wt_scale;
    logic [23:0] wt_value;
    logic set_en = 0;
    logic [23:0] set_val = 24'h00_0000;
    logic [23:0] flow = 24'h00_0000;
    logic [2:0] scale = 3'h0;
    logic motion = 0;
    logic [31:0] rv;
    logic [23:0] pre_w [4] = '{24'h00_01F4, 24'h00_05DC, 24'h00_07D0, 24'h00_03FC};
    logic [23:0] hit_w [4] = '{24'h00_04B0, 24'h00_0320, 24'h00_0406, 24'h00_044C};
    int fails = 0;
    int n_tests = 0;
    int n;

    always #5 clk_sys = ~clk_sys;

    wsc_setpoint #(.TICK_CYC(5)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .wt_valid(wt_valid), .wt_scale(wt_scale), .wt_value(wt_value),
        .standstill(standstill), .feeder_out_q(feeder_out_q), .satisfied_q(satisfied_q),
        .batch_done_q(batch_done_q));

    wsc_scale_model i_mod (.clk_sys(clk_sys), .nrst(nrst), .set_en(set_en),
        .set_val(set_val), .flow(flow), .scale(scale), .feeder_out_q(feeder_out_q),
        .wt_valid(wt_valid), .wt_scale(wt_scale), .wt_value(wt_value),
        .standstill(standstill), .motion(motion));

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata_q;
    endtask

    task put(input logic [23:0] v);
        @(posedge clk_sys);
        set_en <= 1'b1;
        set_val <= v;
        @(posedge clk_sys);
        set_en <= 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
    endtask

    // Start a batch from weight w0 and wait for the trip pulse
    task run_batch(input logic [23:0] w0, input logic [23:0] f);
        flow <= 24'h00_0000;
        put(w0);
        flow <= f;
        wr(A_CMD, 32'h0000_0001);
        @(posedge clk_sys);
        #1;
        chk("feed_on", feeder_out_q, 1);
        n = 0;
        while (batch_done_q !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("done", batch_done_q, 1);
        chk("feed_off", feeder_out_q, 0);
    endtask

    task wrap_up;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #300_000;
        fails++;
        wrap_up;
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(A_FACTOR);
        chk("factor", rv, 32'h0000_8000);
        rd(A_RELEARN);
        chk("relearn", rv, 32'h0000_0001);
        rd(A_STATUS);
        chk("status", rv, 32'h0000_0004);
        rd(8'h30);
        chk("unmapped", rv, 32'h0000_0000);
        wr(A_TARGET, 32'h00FF_FFFF);
        rd(A_TARGET);
        chk("tgt_max", rv, {8'h00, VAL_MAX});
        wr(A_HALF, 32'h00FF_FFFF);
        rd(A_HALF);
        chk("half_max", rv, {8'h00, VAL_MAX});
        wr(A_OFFSET, 32'h00FF_FFFF);
        rd(A_OFFSET);
        chk("off_max", rv, {8'h00, VAL_MAX});
        wr(A_TARGET, 32'h0000_03E8);
        wr(A_HALF, 32'h0000_0032);
        wr(A_REARM, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(A_CTRL, 32'(i) << CTL_TRIP);
            put(pre_w[i]);
            chk("sat_pre", satisfied_q, 0);
            put(hit_w[i]);
            chk("sat_hit", satisfied_q, 1);
            chk("cont_out", feeder_out_q, 1);
        end
        wr(A_CTRL, 32'h0000_0000);
        wr(A_REARM, 32'h0000_0064);
        put(24'h00_04B0);
        chk("hy_sat", satisfied_q, 1);
        put(24'h00_03B6);
        chk("hy_off", satisfied_q, 0);
        put(24'h00_04B0);
        chk("hy_hold", satisfied_q, 0);
        scale <= 3'h1;
        put(24'h00_0320);
        put(24'h00_04B0);
        chk("src_ign", satisfied_q, 0);
        scale <= 3'h0;
        put(24'h00_0352);
        put(24'h00_04B0);
        chk("hy_rearm", satisfied_q, 1);
        wr(A_REARM, 32'h0000_0000);
        wr(A_OFFSET, 32'h0000_0064);
        wr(A_CTRL, 32'h0000_0050);
        run_batch(24'h00_0000, 24'h00_0032);
        chk("fixed_w", i_mod.w_q, 24'h00_0384);
        rd(A_STATUS);
        chk("count", rv[31:16], 1);
        wr(A_CTRL, 32'h0000_0044);
        run_batch(24'h00_04B0, 24'hFF_FFCE);
        chk("below_w", i_mod.w_q, 24'h00_03B6);
        wr(A_TARGET, 32'h0000_0003);
        wr(A_CTRL, 32'h0000_0041);
        run_batch(24'h00_0000, 24'h00_0000);
        chk("time_ok", n >= 13 && n <= 22, 1);
        wr(A_TARGET, 32'h0000_03E8);
        wr(A_CTRL, 32'h0000_0060);
        run_batch(24'h00_0000, 24'h00_0032);
        repeat (10) @(posedge clk_sys);
        rd(A_OFFSET);
        chk("learn", rv, 32'h0000_0032);
        wr(A_RELEARN, 32'h0000_0002);
        wr(A_SETTLE, 32'h0000_0002);
        motion <= 1'b1;
        run_batch(24'h00_0000, 24'h00_0032);
        rd(A_STATUS);
        chk("no_learn", rv[4:3], 0);
        run_batch(24'h00_0000, 24'h00_0032);
        rd(A_STATUS);
        chk("settling", rv[4:3], 2);
        repeat (20) @(posedge clk_sys);
        rd(A_OFFSET);
        chk("skip", rv, 32'h0000_0032);
        rd(A_STATUS);
        chk("skip_idle", rv[4:3], 0);
        motion <= 1'b0;
        wr(A_CTRL, 32'h0000_0070);
        run_batch(24'h00_0000, 24'h00_0032);
        chk("flow_w", i_mod.w_q, 24'h00_0384);
        wr(A_CTRL, 32'h0000_0002);
        wr(A_TARGET, 32'h0000_0008);
        rd(A_STATUS);
        chk("cnt_low", rv[0], 0);
        wr(A_TARGET, 32'h0000_0007);
        rd(A_STATUS);
        chk("cnt_hit", rv[0], 1);
        wr(A_CMD, 32'h0000_0002);
        rd(A_STATUS);
        chk("clr_cnt", rv[31:16], 0);
        wrap_up;
    end
endmodule
